/* design/fspc_pkg.sv */
// shared constants and types for the flash self-program controller
package fspc_pkg;
  localparam logic [5:0] FSPC_CSR_ADDR = 6'h37;
  localparam logic [7:0] FSPC_CSR_RESET = 8'h00;
  localparam int FSPC_BIT_IE = 7;
  localparam int FSPC_BIT_BUSY = 6;
  localparam int FSPC_BIT_SIG = 5;
  localparam int FSPC_BIT_RRE = 4;
  localparam int FSPC_BIT_LOCK = 3;
  localparam int FSPC_BIT_PGWR = 2;
  localparam int FSPC_BIT_PGER = 1;
  localparam int FSPC_BIT_EN = 0;
  localparam logic [4:0] FSPC_CMD_SIG = 5'h01;
  localparam logic [4:0] FSPC_CMD_RRE = 5'h11;
  localparam logic [4:0] FSPC_CMD_PGWR = 5'h05;
  localparam logic [4:0] FSPC_CMD_PGER = 5'h03;
  localparam logic [4:0] FSPC_CMD_FILL = 5'h01;
  localparam logic [4:0] FSPC_CMD_LOCK = 5'h09;
  localparam logic [2:0] FSPC_STORE_WINDOW = 3'h4;
  localparam logic [2:0] FSPC_LOAD_WINDOW = 3'h3;
  typedef enum logic [2:0] {
    FSPC_OP_NONE, FSPC_OP_FILL, FSPC_OP_ERASE, FSPC_OP_WRITE,
    FSPC_OP_REENABLE, FSPC_OP_LOCK, FSPC_OP_SIG
  } fspc_op_t;
endpackage

/* design/fspc_window.sv */
// arming window counter: runs a fixed number of cycles after a start pulse
`timescale 1ns/100ps
module fspc_window (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // control
  input wire logic start,
  input wire logic stop,
  // status
  output logic [2:0] left
);
  typedef struct packed {
    logic [2:0] cnt;
  } fspc_win_t;
  fspc_win_t st_r;
  fspc_win_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (start) begin
      st_nxt.cnt = fspc_pkg::FSPC_STORE_WINDOW;
    end else if (stop) begin
      st_nxt.cnt = 3'h0;
    end else if (st_r.cnt != 3'h0) begin
      st_nxt.cnt = st_r.cnt - 3'h1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign left = st_r.cnt;
endmodule

/* design/fspc_control.sv */
// flash self-program control and status register with command sequencing
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
//
// How it works
// - ready interrupt requested while enabled, global flag set and store enable clear.
// - ready interrupt suppressed during EEPROM write or store operation.
// - without read-while-write variant, section busy always reads zero.
// - section busy reads one while read-while-write section is blocked.
// - signature command lets a load within three cycles return signature byte.
// - store within four cycles after signature command does nothing.
// - writing re-enable during buffer fill clears the page buffer.
// - lock command lets a load within three cycles read lock or fuse byte.
// - page write command makes next store write buffer to Z page.
// - page write bit clears on completion or after four idle cycles.
// - page erase command makes next store erase the Z page.
// - page erase bit clears on completion or after four idle cycles.
// - store enable permits a store only in the next four cycles.
// - store enable alone makes next store fill buffer word at Z.
// - store enable clears after a store or four idle cycles.
// - store enable stays high until erase or write completes.
// - low five bits written only for the five permitted patterns.
// - store starts programming only when executed from boot loader section.
// - programming the read-while-write section still allows no-read-while-write fetches.
// - programming the no-read-while-write section halts the processor.
// - boot loader section always lies in no-read-while-write section.
module fspc_control #(
  parameter bit HAS_RWW = 1'b1
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // register port
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // core instruction strobes
  input wire logic store_exec,
  input wire logic load_exec,
  input wire logic from_boot_section,
  input wire logic target_in_no_read_while_write_section,
  input wire logic pointer_bit_zero,
  input wire logic global_int_enable,
  input wire logic eeprom_write_busy,
  // flash macro side
  output logic fill_buffer,
  output logic clear_buffer,
  output logic erase_page,
  output logic write_page,
  input wire logic flash_done,
  output logic halt_core,
  output logic rww_blocked,
  // load redirection
  output logic load_sig,
  output logic load_lock,
  output logic load_fuse,
  // interrupt request
  output logic ready_irq
);
  typedef struct packed {
    logic ie;
    logic busy;
    logic [4:0] cmd;
    logic sig;
    logic prog;
    logic halt;
    logic filling;
    logic [7:0] rdata;
    logic fill;
    logic clr;
    logic ers;
    logic wrp;
    logic [2:0] ldwin;
  } fspc_state_t;
  fspc_state_t st_r;
  fspc_state_t st_nxt;
  logic csr_wr;
  logic cmd_ok;
  logic [2:0] win_left;
  logic store_ok;
  logic win_stop;
  logic [7:0] csr_view;
  fspc_pkg::fspc_op_t op_now;
  logic arm_sig;
  logic arm_lock;
  logic do_fill;
  logic do_erase;
  logic do_write;
  logic do_rre;
  logic do_void;
  logic new_sig;
  logic new_clear;
  logic ld_open;
  logic irq_block;
  logic cmd_expired;
  logic prog_done;
  logic rd_hit;

  ////////////////////////////////////////////////////////////////////////////
  // arming window

  assign csr_wr = reg_wr && (reg_addr == fspc_pkg::FSPC_CSR_ADDR);
  always_comb begin
    cmd_ok = 1'b0;
    case (reg_wdata[4:0])
      fspc_pkg::FSPC_CMD_RRE,
      fspc_pkg::FSPC_CMD_LOCK,
      fspc_pkg::FSPC_CMD_PGWR,
      fspc_pkg::FSPC_CMD_PGER,
      fspc_pkg::FSPC_CMD_FILL: cmd_ok = !st_r.prog;
      default: cmd_ok = 1'b0;
    endcase
  end
  // a store from the application section is dropped, never queued
  assign store_ok = store_exec && (win_left != 3'h0)
    && from_boot_section;
  assign win_stop = store_ok;

  ////////////////////////////////////////////////////////////////////////////
  // request qualification

  // an unused arm lapses once the window runs dry
  assign cmd_expired = !st_r.prog && (st_r.cmd != 5'h00) && (win_left == 3'h0);
  assign prog_done = st_r.prog && flash_done;
  assign rd_hit = reg_rd && (reg_addr == fspc_pkg::FSPC_CSR_ADDR);

  fspc_window u_win (
    .clock(clock),
    .reset_n(reset_n),
    .start(csr_wr && cmd_ok),
    .stop(win_stop),
    .left(win_left)
  );

  ////////////////////////////////////////////////////////////////////////////
  // armed command decode

  // signature read shares the plain enable pattern and is told apart by its own bit
  always_comb begin
    op_now = fspc_pkg::FSPC_OP_NONE;
    case (st_r.cmd)
      fspc_pkg::FSPC_CMD_FILL: begin
        if (st_r.sig) begin
          op_now = fspc_pkg::FSPC_OP_SIG;
        end else begin
          op_now = fspc_pkg::FSPC_OP_FILL;
        end
      end
      fspc_pkg::FSPC_CMD_PGER: begin
        op_now = fspc_pkg::FSPC_OP_ERASE;
      end
      fspc_pkg::FSPC_CMD_PGWR: begin
        op_now = fspc_pkg::FSPC_OP_WRITE;
      end
      fspc_pkg::FSPC_CMD_RRE: begin
        op_now = fspc_pkg::FSPC_OP_REENABLE;
      end
      fspc_pkg::FSPC_CMD_LOCK: begin
        op_now = fspc_pkg::FSPC_OP_LOCK;
      end
      default: begin
        op_now = fspc_pkg::FSPC_OP_NONE;
      end
    endcase
  end
  assign arm_sig = (op_now == fspc_pkg::FSPC_OP_SIG);
  assign arm_lock = (op_now == fspc_pkg::FSPC_OP_LOCK);

  ////////////////////////////////////////////////////////////////////////////
  // store dispatch

  // a store that meets no store command is swallowed so it cannot fill the buffer
  always_comb begin
    do_fill = 1'b0;
    do_erase = 1'b0;
    do_write = 1'b0;
    do_rre = 1'b0;
    do_void = 1'b0;
    if (store_ok && !st_r.prog) begin
      case (op_now)
        fspc_pkg::FSPC_OP_FILL: begin
          do_fill = 1'b1;
        end
        fspc_pkg::FSPC_OP_ERASE: begin
          do_erase = 1'b1;
        end
        fspc_pkg::FSPC_OP_WRITE: begin
          do_write = 1'b1;
        end
        fspc_pkg::FSPC_OP_REENABLE: begin
          do_rre = 1'b1;
        end
        default: begin
          do_void = 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register write decode

  always_comb begin
    new_sig = 1'b0;
    new_clear = 1'b0;
    if (csr_wr && cmd_ok) begin
      new_sig = reg_wdata[fspc_pkg::FSPC_BIT_SIG]
        && (reg_wdata[4:0] == fspc_pkg::FSPC_CMD_SIG);
      // a re-enable during a fill throws away the half-filled buffer
      new_clear = reg_wdata[fspc_pkg::FSPC_BIT_RRE] && st_r.filling;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command sequencing

  always_comb begin
    st_nxt = st_r;
    st_nxt.fill = 1'b0;
    st_nxt.clr = 1'b0;
    st_nxt.ers = 1'b0;
    st_nxt.wrp = 1'b0;
    if (st_r.ldwin != 3'h0) begin
      st_nxt.ldwin = st_r.ldwin - 3'h1;
    end
    if (cmd_expired) begin
      st_nxt.cmd = 5'h00;
    end
    if (do_fill) begin
      st_nxt.fill = 1'b1;
      st_nxt.filling = 1'b1;
      st_nxt.cmd = 5'h00;
    end
    if (do_erase || do_write) begin
      st_nxt.ers = do_erase;
      st_nxt.wrp = do_write;
      if (do_write) begin
        st_nxt.filling = 1'b0;
      end
      st_nxt.prog = 1'b1;
      st_nxt.halt = target_in_no_read_while_write_section;
      st_nxt.busy = HAS_RWW && !target_in_no_read_while_write_section;
    end
    if (do_rre) begin
      st_nxt.busy = 1'b0;
      st_nxt.cmd = 5'h00;
    end
    if (do_void) begin
      st_nxt.cmd = 5'h00;
    end
    if (prog_done) begin
      st_nxt.prog = 1'b0;
      st_nxt.halt = 1'b0;
      st_nxt.cmd = 5'h00;
    end
    if (csr_wr) begin
      st_nxt.ie = reg_wdata[fspc_pkg::FSPC_BIT_IE];
      if (cmd_ok) begin
        st_nxt.cmd = reg_wdata[4:0];
        st_nxt.ldwin = fspc_pkg::FSPC_LOAD_WINDOW;
        st_nxt.sig = new_sig;
        if (new_clear) begin
          st_nxt.clr = 1'b1;
          st_nxt.filling = 1'b0;
        end
      end
    end
    if (load_exec) begin
      st_nxt.ldwin = 3'h0;
    end
    // the signature flag never outlives its command
    if (st_nxt.cmd == 5'h00) begin
      st_nxt.sig = 1'b0;
    end
    if (!HAS_RWW) begin
      st_nxt.busy = 1'b0;
    end
    st_nxt.rdata = 8'h00;
    if (rd_hit) begin
      st_nxt.rdata = csr_view;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status view

  // busy is tied low on the variant without read-while-write
  for (genvar b = 0; b < $bits(csr_view); b++) begin : g_view
    if (b == fspc_pkg::FSPC_BIT_IE) begin : g_ie
      assign csr_view[b] = st_r.ie;
    end else if (b == fspc_pkg::FSPC_BIT_BUSY) begin : g_busy
      assign csr_view[b] = st_r.busy && HAS_RWW;
    end else if (b == fspc_pkg::FSPC_BIT_SIG) begin : g_sig
      assign csr_view[b] = st_r.sig;
    end else begin : g_cmd
      assign csr_view[b] = st_r.cmd[b];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata = st_r.rdata;
  assign fill_buffer = st_r.fill;
  assign clear_buffer = st_r.clr;
  assign erase_page = st_r.ers;
  assign write_page = st_r.wrp;
  assign halt_core = st_r.halt;
  assign rww_blocked = st_r.busy;
  // loads redirect only while the load window is open; later loads read flash
  assign ld_open = load_exec && (st_r.ldwin != 3'h0);
  always_comb begin
    load_sig = 1'b0;
    load_lock = 1'b0;
    load_fuse = 1'b0;
    if (ld_open) begin
      if (arm_sig) begin
        load_sig = 1'b1;
      end else if (arm_lock) begin
        load_lock = !pointer_bit_zero;
        load_fuse = pointer_bit_zero;
      end
    end
  end
  assign irq_block = st_r.cmd[fspc_pkg::FSPC_BIT_EN] || st_r.prog
    || eeprom_write_busy;
  assign ready_irq = st_r.ie && global_int_enable && !irq_block;
endmodule

/* sim/fspc_properties.sv */
// port assertions for the flash self-program controller
`timescale 1ns/100ps
module fspc_properties (
  // clock, reset and core inputs
  input wire logic clock, reset_n, store_exec, load_exec, from_boot_section,
  input wire logic target_in_no_read_while_write_section, pointer_bit_zero, global_int_enable, eeprom_write_busy,
  // controller outputs
  input wire logic fill_buffer, erase_page, write_page, halt_core,
  input wire logic load_sig, load_lock, load_fuse, ready_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_ig; ready_irq |-> global_int_enable && !eeprom_write_busy; endproperty
  a_ig: assert property (p_ig) else $error("irq gate");
  property p_io; ready_irq |-> !(halt_core || erase_page || write_page); endproperty
  a_io: assert property (p_io) else $error("irq in op");
  property p_fl; fill_buffer |-> $past(store_exec && from_boot_section); endproperty
  a_fl: assert property (p_fl) else $error("fill cause");
  property p_er; erase_page |-> $past(store_exec && from_boot_section); endproperty
  a_er: assert property (p_er) else $error("erase cause");
  property p_wr; write_page |-> $past(store_exec && from_boot_section); endproperty
  a_wr: assert property (p_wr) else $error("write cause");
  property p_sg; load_sig |-> load_exec && !load_lock && !load_fuse; endproperty
  a_sg: assert property (p_sg) else $error("sig load");
  property p_lk; load_lock || load_fuse |->
    load_exec && load_lock != load_fuse && load_fuse == pointer_bit_zero; endproperty
  a_lk: assert property (p_lk) else $error("lock load");
  property p_ht; $rose(halt_core) |-> target_in_no_read_while_write_section && $past(store_exec); endproperty
  a_ht: assert property (p_ht) else $error("halt cause");
  c_fl: cover property (fill_buffer);
  c_er: cover property (erase_page && halt_core);
  c_sg: cover property (load_sig);
endmodule
bind fspc_control fspc_properties u_props (.*);

/* sim/fspc_core_model.sv */
// core model: strobes stores and loads
`timescale 1ns/100ps
module fspc_core_model (
  // bench requests and core status
  input wire logic do_store, do_load, halt_core,
  // instruction strobes
  output logic store_exec, load_exec
);
  // a halted core fetches nothing, so it issues no strobe
  assign store_exec = do_store && !halt_core;
  assign load_exec = do_load && !halt_core;
endmodule

/* sim/tb_top.sv */
// bench for the flash self-program controller
`timescale 1ns/100ps
module tb_top;
  logic clock = 1'h0, reset_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, do_store = 1'h0;
  logic do_load = 1'h0, from_boot_section = 1'h1, target_in_no_read_while_write_section = 1'h1, flash_done = 1'h0;
  logic pointer_bit_zero = 1'h0, global_int_enable = 1'h1, eeprom_write_busy = 1'h0;
  logic store_exec, load_exec, fill_buffer, clear_buffer, erase_page, write_page, halt_core;
  logic rww_blocked, load_sig, load_lock, load_fuse, ready_irq;
  logic [5:0] reg_addr = 6'h37;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  int fail_count = 0, n_compared = 0;
  fspc_control dut (.*);
  fspc_core_model core (.*);
  initial forever #20 clock = ~clock;
  task chk(string w, logic [7:0] s, logic [7:0] e);
    n_compared++;
    if (s !== e) fail_count++;
    if (s !== e) $display("CHECK FAILED %s exp %h seen %h", w, e, s);
  endtask
  task final_report;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task wr(logic [7:0] d);
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clock) reg_wr <= 1'h0;
  endtask
  task rc(logic [5:0] a, logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clock) reg_rd <= 1'h0;
    reg_addr <= 6'h37;
    #1 chk("read", reg_rdata, e);
  endtask
  // checks halt, fill, erase, write in the cycle after the store
  task st(logic b, logic [3:0] e);
    from_boot_section <= b;
    do_store <= 1'h1;
    @(posedge clock) do_store <= 1'h0;
    #1 chk("store", {4'h0, halt_core, fill_buffer, erase_page, write_page}, {4'h0, e});
  endtask
  task ld(logic z, logic [2:0] e);
    pointer_bit_zero <= z;
    do_load <= 1'h1;
    #1 chk("load", {5'h00, load_sig, load_lock, load_fuse}, {5'h00, e});
    @(posedge clock) do_load <= 1'h0;
  endtask
  task t_fill;
    rc(6'h37, 8'h00);
    rc(6'h10, 8'h00);
    wr(8'h01);
    st(1'h1, 4'h4);
    rc(6'h37, 8'h00);
    wr(8'h01);
    repeat (4) @(posedge clock);
    st(1'h1, 4'h0);
    wr(8'h01);
    st(1'h0, 4'h0);
    repeat (4) @(posedge clock);
    wr(8'h07);
    rc(6'h37, 8'h00);
    wr(8'h11);
    #1 chk("clear", {6'h00, rww_blocked, clear_buffer}, 8'h01);
  endtask
  task t_prog;
    wr(8'h03);
    st(1'h1, 4'hA);
    flash_done <= 1'h1;
    @(posedge clock) flash_done <= 1'h0;
    #1 chk("halt", halt_core, 1'h0);
    target_in_no_read_while_write_section <= 1'h0;
    wr(8'h05);
    st(1'h1, 4'h1);
    chk("rww", rww_blocked, 1'h1);
    rc(6'h37, 8'h45);
    flash_done <= 1'h1;
    @(posedge clock) flash_done <= 1'h0;
    rc(6'h37, 8'h40);
    wr(8'h11);
    st(1'h1, 4'h0);
    rc(6'h37, 8'h00);
  endtask
  task t_load;
    wr(8'h21);
    ld(1'h0, 3'h4);
    wr(8'h21);
    st(1'h1, 4'h0);
    repeat (4) @(posedge clock);
    wr(8'h09);
    ld(1'h1, 3'h1);
    wr(8'h09);
    ld(1'h0, 3'h2);
    repeat (4) @(posedge clock);
    wr(8'h80);
    #1 chk("irq", ready_irq, 1'h1);
    eeprom_write_busy <= 1'h1;
    #1 chk("irq ee", ready_irq, 1'h0);
  endtask
  initial begin
    repeat (12) @(posedge clock);
    reset_n <= 1'h1;
    @(posedge clock);
    t_fill;
    t_prog;
    t_load;
    final_report;
  end
  initial begin
    #40000;
    fail_count++;
    final_report;
  end
endmodule
